// ---- hdl/hw_monitor_alert_logic.sv ----
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module hw_monitor_alert_logic #(
  parameter int unsigned TONE_PHASE_CYCLES = alert_pkg::TONE_PHASE_CYCLES,
  parameter int unsigned LOW_HALF_CYCLES = alert_pkg::LOW_HALF_CYCLES,
  parameter int unsigned HIGH_HALF_CYCLES = alert_pkg::HIGH_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [alert_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [alert_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [alert_pkg::DATA_W-1:0] hrdata,
  input wire logic meas_valid,
  input wire logic [alert_pkg::CHAN_W-1:0] meas_chan,
  input wire logic [7:0] meas_value,
  input wire logic intrusion_n,
  output logic mgmt_irq_n,
  output logic overtemp_n,
  output logic alarm_tone_out,
  output logic alarm_tone_oe
);
  import alert_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  logic [7:0] wr_addr;
  logic [7:0] next_wr_addr;
  logic wr_pend;
  logic next_wr_pend;
  logic [DATA_W-1:0] next_hrdata;
  logic [7:0] pin_mode;
  logic [7:0] next_pin_mode;
  logic [7:0] therm_mode;
  logic [7:0] next_therm_mode;
  logic [7:0] ovt_mode;
  logic [7:0] next_ovt_mode;
  logic [7:0] case_clr;
  logic [7:0] next_case_clr;
  logic [15:0] alarm_tone_out_ctrl;
  logic [15:0] next_alarm_tone_out_ctrl;
  logic [15:0] limit_mem [NUM_CHAN];
  logic [15:0] next_limit_mem [NUM_CHAN];
  logic acc;
  logic rd_take;
  logic status_rd;
  logic [11:0] status;
  logic [11:0] next_status;
  logic [11:0] evt;
  logic [NUM_VOLT-1:0] volt_oor;
  logic [NUM_VOLT-1:0] next_volt_oor;
  logic [NUM_FAN-1:0] fan_above;
  logic [NUM_FAN-1:0] next_fan_above;
  logic case_prev;
  logic case_latch;
  logic next_case_latch;
  logic ovt_latch;
  logic next_ovt_latch;
  logic next_mgmt_irq_n;
  logic next_overtemp_n;
  logic next_tone_oe;
  logic smi_mode;
  logic ovt_int;
  logic hot_any;
  logic ovt_edge_any;
  logic alarm_tone_out_on;
  logic [12:0] alarm_tone_out_cond;
  logic board_smi;
  logic board_edge;
  logic board_hot;
  logic proc_smi;
  logic proc_edge;
  logic proc_hot;

  // ************************************************************
  // address decode helpers
  // ************************************************************
  function automatic logic is_limit(input logic [7:0] a);
    is_limit = (a >= ADDR_LIMIT_BASE) && (a < ADDR_LIMIT_BASE + 8'(4 * NUM_CHAN)) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] limit_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_LIMIT_BASE;
    limit_idx = d[5:2];
  endfunction

  // ************************************************************
  // bus slave: zero wait, read data registered at address phase
  // ************************************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel && hready && htrans[1];
  assign rd_take = acc && !hwrite && (haddr[31:8] == 24'h0);
  // status read is the only re-arm path for the management interrupt
  assign status_rd = rd_take && (haddr[7:0] == ADDR_STATUS);

  always_comb begin
    next_wr_pend = acc && hwrite && (hsize == HSIZE_WORD) && (haddr[31:8] == 24'h0);
    next_wr_addr = haddr[7:0];
    next_hrdata = hrdata;
    if (rd_take) begin
      next_hrdata = '0;
      if (is_limit(haddr[7:0])) begin
        next_hrdata[15:0] = limit_mem[limit_idx(haddr[7:0])];
      end else begin
        case (haddr[7:0])
          ADDR_STATUS: next_hrdata[12:0] = {case_latch, status};
          ADDR_LIVE: next_hrdata[13:0] = {case_latch, intrusion_n, proc_hot, board_hot, fan_above, volt_oor};
          ADDR_PIN_MODE: next_hrdata[7:0] = pin_mode;
          ADDR_THERM_MODE: next_hrdata[7:0] = therm_mode;
          ADDR_OVT_MODE: next_hrdata[7:0] = ovt_mode;
          ADDR_CASE_CLR: next_hrdata[7:0] = case_clr;
          ADDR_ALARM_TONE_OUT_CTRL: next_hrdata[15:0] = alarm_tone_out_ctrl;
          default: next_hrdata = '0;
        endcase
      end
    end
  end

  // ************************************************************
  // writable registers, written in the data phase
  // ************************************************************
  always_comb begin
    next_pin_mode = pin_mode;
    next_therm_mode = therm_mode;
    next_ovt_mode = ovt_mode;
    next_alarm_tone_out_ctrl = alarm_tone_out_ctrl;
    next_limit_mem = limit_mem;
    next_case_clr = 8'h00;
    if (wr_pend) begin
      if (is_limit(wr_addr)) begin
        next_limit_mem[limit_idx(wr_addr)] = hwdata[15:0];
      end
      case (wr_addr)
        ADDR_PIN_MODE: next_pin_mode = hwdata[7:0];
        ADDR_THERM_MODE: next_therm_mode = hwdata[7:0];
        ADDR_OVT_MODE: next_ovt_mode = hwdata[7:0];
        ADDR_ALARM_TONE_OUT_CTRL: next_alarm_tone_out_ctrl = hwdata[15:0];
        // clear bits hold one cycle then drop back by themselves
        ADDR_CASE_CLR: begin
          next_case_clr[CASE_CLR_BIT] = hwdata[CASE_CLR_BIT];
          next_case_clr[CASE_ALT_CLR_BIT] = hwdata[CASE_ALT_CLR_BIT];
        end
        default: next_case_clr = 8'h00;
      endcase
    end
  end

  // ************************************************************
  // temperature sensor units
  // ************************************************************
  // board sensor compares without hysteresis in comparator mode
  temp_alert_unit #(
    .HOLD_TO_HYST(1'b0)
  ) board_unit (
    .clk_sys(clk_sys),
    .srst(srst),
    .sample(meas_valid && (meas_chan == BOARD_TEMP_CHAN)),
    .value(meas_value),
    .over_lim(limit_mem[BOARD_TEMP_BIT][HI_LSB +: 8]),
    .hyst_lim(limit_mem[BOARD_TEMP_BIT][LO_LSB +: 8]),
    .cmp_mode(limit_mem[BOARD_TEMP_BIT][LO_LSB +: 8] == CMP_HYST),
    .one_time(therm_mode[ONE_TIME_BIT]),
    .smi_evt(board_smi),
    .ovt_edge(board_edge),
    .hot(board_hot)
  );

  temp_alert_unit #(
    .HOLD_TO_HYST(1'b1)
  ) proc_unit (
    .clk_sys(clk_sys),
    .srst(srst),
    .sample(meas_valid && (meas_chan == PROC_TEMP_CHAN)),
    .value(meas_value),
    .over_lim(limit_mem[PROC_TEMP_BIT][HI_LSB +: 8]),
    .hyst_lim(limit_mem[PROC_TEMP_BIT][LO_LSB +: 8]),
    .cmp_mode(therm_mode[PROC_CMP_BIT]),
    .one_time(1'b0),
    .smi_evt(proc_smi),
    .ovt_edge(proc_edge),
    .hot(proc_hot)
  );

  // ************************************************************
  // voltage and fan comparison, status and pin personalities
  // ************************************************************
  assign smi_mode = pin_mode[SMI_MODE_BIT];
  assign ovt_int = ovt_mode[OVT_INT_A_BIT] && ovt_mode[OVT_INT_B_BIT];
  assign hot_any = (ovt_mode[BOARD_OVT_EN_BIT] && board_hot) || (therm_mode[PROC_OVT_EN_BIT] && proc_hot);
  assign ovt_edge_any = (ovt_mode[BOARD_OVT_EN_BIT] && board_edge) || (therm_mode[PROC_OVT_EN_BIT] && proc_edge);

  always_comb begin
    evt = '0;
    next_volt_oor = volt_oor;
    next_fan_above = fan_above;
    for (int i = 0; i < NUM_VOLT; i++) begin
      if (meas_valid && (meas_chan == 4'(i))) begin
        next_volt_oor[i] = (meas_value > limit_mem[i][HI_LSB +: 8]) || (meas_value < limit_mem[i][LO_LSB +: 8]);
        evt[i] = next_volt_oor[i];
      end
    end
    for (int j = 0; j < NUM_FAN; j++) begin
      if (meas_valid && (meas_chan == FAN0_CHAN + 4'(j))) begin
        next_fan_above[j] = meas_value > limit_mem[NUM_VOLT + j][LO_LSB +: 8];
        evt[NUM_VOLT + j] = next_fan_above[j] != fan_above[j];
      end
    end
    evt[BOARD_TEMP_BIT] = board_smi;
    evt[PROC_TEMP_BIT] = proc_smi;
    // a new event in the read cycle is kept: set wins over clear
    next_status = (status & ~{12{status_rd}}) | evt;
    // pending status keeps the line low; later events add no new edge
    next_mgmt_irq_n = !(smi_mode && (|next_status));
    next_ovt_latch = ovt_int && (ovt_edge_any || (ovt_latch && !status_rd));
    next_overtemp_n = !(!smi_mode && (ovt_int ? next_ovt_latch : hot_any));
    // an edge in the clear cycle still wins, nothing is lost
    next_case_latch = (case_prev && !intrusion_n) || (case_latch && !(case_clr[CASE_CLR_BIT] || case_clr[CASE_ALT_CLR_BIT]));
  end

  // ************************************************************
  // beeper source merge and open-drain drive
  // ************************************************************
  assign alarm_tone_out_cond = {!intrusion_n, proc_hot, board_hot, fan_above, volt_oor};
  assign alarm_tone_out_on = alarm_tone_out_ctrl[ALARM_TONE_OUT_GLOBAL_BIT] && (alarm_tone_out_ctrl[ALARM_TONE_OUT_USER_BIT] || (|(alarm_tone_out_cond & alarm_tone_out_ctrl[12:0])));

  alarm_tone_gen #(
    .PHASE_CYCLES(TONE_PHASE_CYCLES),
    .LOW_HALF(LOW_HALF_CYCLES),
    .HIGH_HALF(HIGH_HALF_CYCLES)
  ) tone_unit (
    .clk_sys(clk_sys),
    .srst(srst),
    .active(alarm_tone_out_on && !pin_mode[GPIO_MODE_BIT]),
    .tone(alarm_tone_out)
  );

  // pin is released in gpio mode; open drain only ever pulls low
  assign next_tone_oe = !pin_mode[GPIO_MODE_BIT] && !alarm_tone_out;

  // ************************************************************
  // state registers
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= '0;
      pin_mode <= CFG_RESET;
      therm_mode <= CFG_RESET;
      ovt_mode <= CFG_RESET;
      case_clr <= CFG_RESET;
      alarm_tone_out_ctrl <= ALARM_TONE_OUT_RESET;
      for (int k = 0; k < NUM_CHAN; k++) begin
        limit_mem[k] <= LIMIT_RESET;
      end
      status <= '0;
      volt_oor <= '0;
      fan_above <= '0;
      case_prev <= 1'b1;
      case_latch <= 1'b0;
      ovt_latch <= 1'b0;
      mgmt_irq_n <= 1'b1;
      overtemp_n <= 1'b1;
      alarm_tone_oe <= 1'b1;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      pin_mode <= next_pin_mode;
      therm_mode <= next_therm_mode;
      ovt_mode <= next_ovt_mode;
      case_clr <= next_case_clr;
      alarm_tone_out_ctrl <= next_alarm_tone_out_ctrl;
      limit_mem <= next_limit_mem;
      status <= next_status;
      volt_oor <= next_volt_oor;
      fan_above <= next_fan_above;
      case_prev <= intrusion_n;
      case_latch <= next_case_latch;
      ovt_latch <= next_ovt_latch;
      mgmt_irq_n <= next_mgmt_irq_n;
      overtemp_n <= next_overtemp_n;
      alarm_tone_oe <= next_tone_oe;
    end
  end
endmodule // hw_monitor_alert_logic
`default_nettype wire

// ---- hdl/alert_pkg.sv ----
package alert_pkg;

  // ************************************************************
  // clock and tone timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned LOW_TONE_HZ = 600;
  localparam int unsigned HIGH_TONE_HZ = 1200;
  localparam int unsigned TONE_PHASE_MS = 500;
  // half periods round down so the tone never runs slower than nominal
  localparam int unsigned LOW_HALF_CYCLES = CLK_HZ / (2 * LOW_TONE_HZ);
  localparam int unsigned HIGH_HALF_CYCLES = CLK_HZ / (2 * HIGH_TONE_HZ);
  localparam int unsigned TONE_PHASE_CYCLES = (CLK_HZ / 1000) * TONE_PHASE_MS;

  // ************************************************************
  // bus and register map
  // ************************************************************
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CHAN_W = 4;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_LIVE = 8'h04;
  localparam logic [7:0] ADDR_PIN_MODE = 8'h08;
  localparam logic [7:0] ADDR_THERM_MODE = 8'h0c;
  localparam logic [7:0] ADDR_OVT_MODE = 8'h10;
  localparam logic [7:0] ADDR_CASE_CLR = 8'h14;
  localparam logic [7:0] ADDR_ALARM_TONE_OUT_CTRL = 8'h18;
  localparam logic [7:0] ADDR_LIMIT_BASE = 8'h40;

  // ************************************************************
  // channels and limit word layout
  // ************************************************************
  localparam int unsigned NUM_CHAN = 12;
  localparam int unsigned NUM_VOLT = 8;
  localparam int unsigned NUM_FAN = 2;
  localparam logic [3:0] FAN0_CHAN = 4'h8;
  localparam logic [3:0] BOARD_TEMP_CHAN = 4'ha;
  localparam logic [3:0] PROC_TEMP_CHAN = 4'hb;
  localparam int unsigned BOARD_TEMP_BIT = 10;
  localparam int unsigned PROC_TEMP_BIT = 11;
  localparam int unsigned HI_LSB = 8;
  localparam int unsigned LO_LSB = 0;
  localparam logic [7:0] CMP_HYST = 8'h7f;

  // ************************************************************
  // control field positions and reset values
  // ************************************************************
  localparam int unsigned SMI_MODE_BIT = 6;
  localparam int unsigned GPIO_MODE_BIT = 1;
  localparam int unsigned ONE_TIME_BIT = 5;
  localparam int unsigned PROC_CMP_BIT = 6;
  localparam int unsigned PROC_OVT_EN_BIT = 3;
  localparam int unsigned BOARD_OVT_EN_BIT = 6;
  localparam int unsigned OVT_INT_A_BIT = 4;
  localparam int unsigned OVT_INT_B_BIT = 1;
  localparam int unsigned CASE_CLR_BIT = 7;
  localparam int unsigned CASE_ALT_CLR_BIT = 5;
  localparam int unsigned INTRUSION_BIT = 12;
  localparam int unsigned ALARM_TONE_OUT_USER_BIT = 13;
  localparam int unsigned ALARM_TONE_OUT_GLOBAL_BIT = 15;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] ALARM_TONE_OUT_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;

  typedef enum logic {TONE_LOW, TONE_HIGH} tone_sel_type;

endpackage

// ---- hdl/temp_alert_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module temp_alert_unit #(
  parameter bit HOLD_TO_HYST = 1'b1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic sample,
  input wire logic [7:0] value,
  input wire logic [7:0] over_lim,
  input wire logic [7:0] hyst_lim,
  input wire logic cmp_mode,
  input wire logic one_time,
  output logic smi_evt,
  output logic ovt_edge,
  output logic hot
);
  import alert_pkg::*;

  logic next_hot;
  logic above;
  logic below;

  // ************************************************************
  // hysteresis tracking and event pulses
  // ************************************************************
  always_comb begin
    above = value > over_lim;
    below = value < hyst_lim;
    next_hot = hot;
    smi_evt = 1'b0;
    ovt_edge = 1'b0;
    if (sample) begin
      if (!hot && above) begin
        next_hot = 1'b1;
        ovt_edge = 1'b1;
        smi_evt = !cmp_mode;
      end else if (hot && below) begin
        next_hot = 1'b0;
        ovt_edge = 1'b1;
        smi_evt = !cmp_mode && !one_time;
      end
      // comparator mode repeats on every sample, even after a status read
      if (cmp_mode) begin
        smi_evt = HOLD_TO_HYST ? next_hot : above;
      end
    end
  end

  // hot level survives between samples
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hot <= 1'b0;
    end else begin
      hot <= next_hot;
    end
  end
endmodule // temp_alert_unit
`default_nettype wire

// ---- hdl/alarm_tone_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module alarm_tone_gen #(
  parameter int unsigned PHASE_CYCLES = alert_pkg::TONE_PHASE_CYCLES,
  parameter int unsigned LOW_HALF = alert_pkg::LOW_HALF_CYCLES,
  parameter int unsigned HIGH_HALF = alert_pkg::HIGH_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic active,
  output logic tone
);
  import alert_pkg::*;

  tone_sel_type sel;
  tone_sel_type next_sel;
  logic [31:0] phase_cnt;
  logic [31:0] next_phase_cnt;
  logic [31:0] half_cnt;
  logic [31:0] next_half_cnt;
  logic [31:0] half_lim;
  logic next_tone;

  // ************************************************************
  // alternating square waves
  // ************************************************************
  always_comb begin
    next_sel = sel;
    next_phase_cnt = phase_cnt + 32'h1;
    next_half_cnt = half_cnt + 32'h1;
    next_tone = tone;
    unique case (sel)
      TONE_LOW: half_lim = 32'(LOW_HALF);
      TONE_HIGH: half_lim = 32'(HIGH_HALF);
    endcase
    if (half_cnt >= half_lim - 32'h1) begin
      next_half_cnt = 32'h0;
      next_tone = ~tone;
    end
    // each pitch lasts one phase, then the other takes over
    if (phase_cnt >= 32'(PHASE_CYCLES) - 32'h1) begin
      next_phase_cnt = 32'h0;
      next_half_cnt = 32'h0;
      next_sel = (sel == TONE_LOW) ? TONE_HIGH : TONE_LOW;
    end
    // idle restarts the sequence at the low pitch, pin level low
    if (!active) begin
      next_sel = TONE_LOW;
      next_phase_cnt = 32'h0;
      next_half_cnt = 32'h0;
      next_tone = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel <= TONE_LOW;
      phase_cnt <= 32'h0;
      half_cnt <= 32'h0;
      tone <= 1'b0;
    end else begin
      sel <= next_sel;
      phase_cnt <= next_phase_cnt;
      half_cnt <= next_half_cnt;
      tone <= next_tone;
    end
  end
endmodule // alarm_tone_gen
`default_nettype wire

// ---- sim/host_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// host side: beeper wire pull-up and interrupt input
// ****
module host_partner (
  input wire logic clk_sys,
  input wire logic mgmt_irq_n,
  input wire logic alarm_tone_oe,
  output logic alarm_tone_out_wire,
  output int irq_edges
);
  logic last_irq = 1'b1;
  // open drain: low only while driven, the pull-up wins otherwise
  assign alarm_tone_out_wire = alarm_tone_oe ? 1'b0 : 1'b1;
  // the input is level sensitive; edges are only logged
  always @(posedge clk_sys) begin
    if (last_irq && !mgmt_irq_n) irq_edges <= irq_edges + 1;
    last_irq <= mgmt_irq_n;
  end
endmodule // host_partner
`default_nettype wire

// ---- sim/hw_monitor_alert_logic_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module alert_checker #(
  parameter int unsigned LOW_HALF_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic meas_valid,
  input wire logic intrusion_n,
  input wire logic mgmt_irq_n,
  input wire logic overtemp_n,
  input wire logic alarm_tone_out,
  input wire logic alarm_tone_oe
);
  logic rd_stat, wr, last_tone;
  int run, next_run;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // software accesses that may release an output
  assign rd_stat = hsel && htrans[1] && !hwrite && haddr == 32'h0;
  assign wr = hsel && htrans[1] && hwrite;
  // length of the present tone level, this cycle included
  always_comb begin
    next_run = (alarm_tone_out == last_tone) ? run + 1 : 1;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      run <= 1;
      last_tone <= 1'b0;
    end else begin
      run <= next_run;
      last_tone <= alarm_tone_out;
    end
  end
  sequence quiet_sw;
    !rd_stat && !wr;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_irq_cause: assert property ($fell(mgmt_irq_n) |-> $past(meas_valid) || !$past(intrusion_n) ||
    $past(wr, 2) || $past(wr, 3)) else $error("interrupt without a cause");
  a_irq_release: assert property ($rose(mgmt_irq_n) |-> $past(rd_stat) || $past(rd_stat, 2) ||
    $past(wr, 2) || $past(wr, 3)) else $error("interrupt released without status read");
  a_irq_hold: assert property (quiet_sw [*3] ##0 !mgmt_irq_n |=> !mgmt_irq_n)
    else $error("interrupt dropped on its own");
  a_pin_exclusive: assert property (!overtemp_n |-> mgmt_irq_n) else $error("both pin modes active");
  a_oe_drive: assert property (alarm_tone_oe |-> !$past(alarm_tone_out)) else $error("beeper drive wrong");
  a_tone_run: assert property (alarm_tone_out |-> next_run <= LOW_HALF_CYCLES)
    else $error("tone high too long");
  a_ovt_cause: assert property ($fell(overtemp_n) |-> $past(meas_valid) || $past(meas_valid, 2) ||
    $past(wr, 2) || $past(wr, 3)) else $error("overtemp without a sample");
endmodule // alert_checker
bind hw_monitor_alert_logic alert_checker #(.LOW_HALF_CYCLES(LOW_HALF_CYCLES)) i_alert_checker (
  .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hreadyout(hreadyout), .hresp(hresp), .meas_valid(meas_valid), .intrusion_n(intrusion_n),
  .mgmt_irq_n(mgmt_irq_n), .overtemp_n(overtemp_n), .alarm_tone_out(alarm_tone_out), .alarm_tone_oe(alarm_tone_oe));
`default_nettype wire

// ---- sim/tb_hw_monitor_alert_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// alert logic bench
// ****
module tb_hw_monitor_alert_logic;
  import alert_pkg::*;
  localparam int unsigned PH = 400;
  localparam int unsigned LH = 20;
  localparam int unsigned HH = 10;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b1;
  logic [ADDR_W-1:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [DATA_W-1:0] hwdata = '0;
  logic [DATA_W-1:0] hrdata, rd;
  logic hreadyout, hresp, mgmt_irq_n, overtemp_n, alarm_tone_out, alarm_tone_oe, alarm_tone_out_wire;
  logic meas_valid = 1'b0;
  logic [CHAN_W-1:0] meas_chan = '0;
  logic [7:0] meas_value = '0;
  logic intrusion_n = 1'b1;
  int irq_edges, n, n_errors = 0, total_checks = 0, cycles = 0;
  hw_monitor_alert_logic #(.TONE_PHASE_CYCLES(PH), .LOW_HALF_CYCLES(LH), .HIGH_HALF_CYCLES(HH))
    i_hw_monitor_alert_logic (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .meas_valid(meas_valid), .meas_chan(meas_chan), .meas_value(meas_value),
    .intrusion_n(intrusion_n), .mgmt_irq_n(mgmt_irq_n), .overtemp_n(overtemp_n),
    .alarm_tone_out(alarm_tone_out), .alarm_tone_oe(alarm_tone_oe));
  host_partner i_host_partner (.clk_sys(clk_sys), .mgmt_irq_n(mgmt_irq_n), .alarm_tone_oe(alarm_tone_oe),
    .alarm_tone_out_wire(alarm_tone_out_wire), .irq_edges(irq_edges));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // a hang ends in the closing report
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // single word transfer; waits on the slave, not on a cycle count
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask
  // extra edges so registered outputs have landed before sampling
  task automatic meas(input logic [3:0] ch, input logic [7:0] v);
    meas_valid <= 1'b1;
    meas_chan <= ch;
    meas_value <= v;
    @(posedge clk_sys);
    meas_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic step(input logic [3:0] ch, input logic [7:0] v, input logic [31:0] exp);
    meas(ch, v);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("status", rd, exp);
  endtask
  task automatic high_run();
    while (alarm_tone_out !== 1'b1) @(posedge clk_sys);
    n = 0;
    while (alarm_tone_out === 1'b1) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic t_reset();
    bus(1'b0, ADDR_PIN_MODE, 32'h0);
    check("pin_mode", rd, {24'h0, CFG_RESET});
    bus(1'b0, ADDR_ALARM_TONE_OUT_CTRL, 32'h0);
    check("alarm_tone_out_ctrl", rd, {16'h0, ALARM_TONE_OUT_RESET});
    bus(1'b0, 8'hfc, 32'h0);
    check("unmapped", rd, 32'h0);
    check("pins", {mgmt_irq_n, overtemp_n, alarm_tone_out, alarm_tone_oe}, 4'hd);
    $display("reset test done");
  endtask
  task automatic t_limits();
    bus(1'b1, ADDR_PIN_MODE, 32'h40);
    bus(1'b1, ADDR_LIMIT_BASE, 32'h8020);
    meas(4'h0, 8'h90);
    check("irq low", mgmt_irq_n, 1'b0);
    check("ovt idle", overtemp_n, 1'b1);
    // an in-range sample adds no event, so only the pending status can hold the line
    meas(4'h0, 8'h50);
    check("irq held", mgmt_irq_n, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    repeat (2) @(posedge clk_sys);
    check("status", rd, 32'h1);
    check("irq free", mgmt_irq_n, 1'b1);
    step(4'h0, 8'h50, 32'h0);
    step(4'h0, 8'h10, 32'h1);
    bus(1'b1, ADDR_LIMIT_BASE + 8'h20, 32'h40);
    step(4'h8, 8'h50, 32'h100);
    step(4'h8, 8'h60, 32'h0);
    step(4'h8, 8'h30, 32'h100);
    $display("limit test done");
  endtask
  task automatic t_temps();
    bus(1'b1, ADDR_LIMIT_BASE + 8'h28, {16'h0, 8'h50, CMP_HYST});
    step(4'ha, 8'h60, 32'h400);
    step(4'ha, 8'h60, 32'h400);
    step(4'ha, 8'h30, 32'h0);
    bus(1'b1, ADDR_LIMIT_BASE + 8'h28, 32'h5040);
    step(4'ha, 8'h60, 32'h400);
    step(4'ha, 8'h60, 32'h0);
    step(4'ha, 8'h30, 32'h400);
    bus(1'b1, ADDR_THERM_MODE, 32'h20);
    step(4'ha, 8'h60, 32'h400);
    step(4'ha, 8'h30, 32'h0);
    step(4'ha, 8'h60, 32'h400);
    bus(1'b1, ADDR_LIMIT_BASE + 8'h2c, 32'h5040);
    bus(1'b1, ADDR_THERM_MODE, 32'h40);
    step(4'hb, 8'h60, 32'h800);
    step(4'hb, 8'h48, 32'h800);
    step(4'hb, 8'h30, 32'h0);
    bus(1'b1, ADDR_THERM_MODE, 32'h0);
    step(4'hb, 8'h60, 32'h800);
    step(4'hb, 8'h60, 32'h0);
    step(4'hb, 8'h30, 32'h800);
    $display("temperature test done");
  endtask
  task automatic t_overtemp();
    bus(1'b1, ADDR_PIN_MODE, 32'h0);
    bus(1'b1, ADDR_OVT_MODE, 32'h40);
    meas(4'ha, 8'h30);
    meas(4'ha, 8'h60);
    check("ovt on", overtemp_n, 1'b0);
    check("irq off", mgmt_irq_n, 1'b1);
    meas(4'ha, 8'h48);
    check("ovt hyst", overtemp_n, 1'b0);
    meas(4'ha, 8'h30);
    check("ovt off", overtemp_n, 1'b1);
    bus(1'b1, ADDR_OVT_MODE, 32'h52);
    bus(1'b0, ADDR_STATUS, 32'h0);
    meas(4'ha, 8'h60);
    meas(4'ha, 8'h30);
    check("ovt latched", overtemp_n, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    repeat (2) @(posedge clk_sys);
    check("ovt reset", overtemp_n, 1'b1);
    bus(1'b1, ADDR_OVT_MODE, 32'h12);
    meas(4'ha, 8'h60);
    check("ovt masked", overtemp_n, 1'b1);
    bus(1'b1, ADDR_THERM_MODE, 32'h8);
    meas(4'hb, 8'h60);
    check("ovt proc", overtemp_n, 1'b0);
    $display("overtemp test done");
  endtask
  task automatic t_intrusion();
    for (int i = 0; i < 2; i++) begin
      intrusion_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      intrusion_n <= 1'b1;
      bus(1'b0, ADDR_LIVE, 32'h0);
      check("live", rd[13:12], 2'h3);
      bus(1'b1, ADDR_CASE_CLR, (i == 0) ? 32'h80 : 32'h20);
      // the latch drops one edge after the clear bit lands
      @(posedge clk_sys);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("latch", rd[12], 1'b0);
      bus(1'b0, ADDR_CASE_CLR, 32'h0);
      check("self clear", rd, 32'h0);
    end
    $display("intrusion test done");
  endtask
  task automatic t_alarm_tone_out();
    bus(1'b1, ADDR_ALARM_TONE_OUT_CTRL, 32'ha000);
    high_run();
    check("low tone", n, LH);
    repeat (PH) @(posedge clk_sys);
    high_run();
    check("high tone", n, HH);
    bus(1'b1, ADDR_ALARM_TONE_OUT_CTRL, 32'h2000);
    repeat (2) @(posedge clk_sys);
    check("gated", alarm_tone_out, 1'b0);
    intrusion_n <= 1'b0;
    bus(1'b1, ADDR_ALARM_TONE_OUT_CTRL, 32'h9000);
    high_run();
    check("case tone", n, LH);
    bus(1'b1, ADDR_PIN_MODE, 32'h2);
    repeat (2) @(posedge clk_sys);
    check("released", {alarm_tone_oe, alarm_tone_out_wire}, 2'h1);
    check("irq seen", irq_edges > 0, 1'b1);
    $display("beeper test done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_limits();
    t_temps();
    t_overtemp();
    t_intrusion();
    t_alarm_tone_out();
    conclude();
  end
endmodule // tb_hw_monitor_alert_logic
`default_nettype wire
